// file: hdl/adc_host_serial_port.sv
// serial host port: command decode, shift in/out, ready flag and pin
// Functional notes
// - on a read the serial output carries the register most significant bit first.
// - a host clock idling high needs the polarity select strapped high.
// - a host clock idling low needs the polarity select strapped low.
// - the status word carries a ready bit set when a new result lands in the data register.
// - an active-low ready output mirrors the ready state for polling or interrupt use.
// - with chip select held active the port works on clock and one shared data line.
// - during a write the serial output is never driven.
// - after any write the port again expects a command byte.
`default_nettype none
module adc_host_serial_port #(
  parameter int unsigned DATA_W = adc_port_pkg::DATA_W,
  parameter int unsigned CMD_W  = adc_port_pkg::CMD_W
) (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              sclk_in,
  input  wire logic              cs_n_in,
  input  wire logic              din_in,
  input  wire logic              clock_polarity_select_in,
  input  wire logic [DATA_W-1:0] result_data_in,
  input  wire logic              result_valid_in,
  output logic                   result_ready_out,
  output logic                   dout_out,
  output logic                   dout_oe_out,
  output logic                   ready_n_out,
  output logic [DATA_W-1:0]      wr_data_out,
  output logic [CMD_W-1:0]       wr_cmd_out,
  output logic                   wr_valid_out,
  input  wire logic              wr_ready_in
);
  ////////////////////////////////////////////////////////////////////////
  logic       rst_q1;
  logic       rst_q2;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end
  wire logic rst_n = rst_q2;

  // three-stage pin sync; change counts when stages 2 and 3 agree
  logic [2:0] sclk_s_q;
  logic [2:0] cs_s_q;
  logic [2:0] din_s_q;
  logic [2:0] pol_s_q;
  logic       sclk_q;
  logic       cs_n_q;
  logic       din_q;
  logic       pol_q;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s_q <= 3'h0;
      cs_s_q   <= 3'h7;
      din_s_q  <= 3'h7;
      pol_s_q  <= 3'h0;
      sclk_q   <= 1'b0;
      cs_n_q   <= 1'b1;
      din_q    <= 1'b1;
      pol_q    <= 1'b0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk_in};
      cs_s_q   <= {cs_s_q[1:0], cs_n_in};
      din_s_q  <= {din_s_q[1:0], din_in};
      pol_s_q  <= {pol_s_q[1:0], clock_polarity_select_in};
      if (sclk_s_q[1] == sclk_s_q[2]) sclk_q <= sclk_s_q[2];
      if (cs_s_q[1] == cs_s_q[2]) cs_n_q <= cs_s_q[2];
      if (din_s_q[1] == din_s_q[2]) din_q <= din_s_q[2];
      if (pol_s_q[1] == pol_s_q[2]) pol_q <= pol_s_q[2];
    end
  end

  // polarity strap folds the clock so both idle levels look alike
  logic       ck_prev_q;
  wire logic  ck_norm   = sclk_q ^ pol_q;
  wire logic  active    = !cs_n_q;
  wire logic  lead_edge = active && !ck_prev_q && ck_norm;
  wire logic  trail_edge = active && ck_prev_q && !ck_norm;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) ck_prev_q <= 1'b0;
    else ck_prev_q <= ck_norm;
  end

  ////////////////////////////////////////////////////////////////////////
  // result buffer: two entries so a busy host loses no result
  logic [DATA_W-1:0] buf_mem_q [2];
  logic              wr_ptr_q;
  logic              rd_ptr_q;
  logic [1:0]        buf_cnt_q;
  logic              buf_pop;
  wire logic         buf_empty = (buf_cnt_q == 2'h0);
  wire logic         buf_push  = result_valid_in && result_ready_out;
  assign result_ready_out = (buf_cnt_q != 2'h2);
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q  <= 1'b0;
      rd_ptr_q  <= 1'b0;
      buf_cnt_q <= 2'h0;
    end else begin
      if (buf_push) wr_ptr_q <= !wr_ptr_q;
      if (buf_pop) rd_ptr_q <= !rd_ptr_q;
      buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end
  always_ff @(posedge clk_in) begin
    if (buf_push) buf_mem_q[wr_ptr_q] <= result_data_in;
  end

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    ST_CMD   = 4'b0001,
    ST_WRITE = 4'b0010,
    ST_READ  = 4'b0100,
    ST_CONT  = 4'b1000
  } port_state_t;
  port_state_t       state_q;
  logic [4:0]        bit_cnt_q;
  logic [4:0]        len_q;
  logic [CMD_W-1:0]  cmd_q;
  logic [DATA_W-1:0] sh_in_q;
  logic [DATA_W-1:0] sh_out_q;
  logic              data_sel_q;
  logic              new_ready_q;
  wire logic [CMD_W-1:0] cmd_next = {cmd_q[CMD_W-2:0], din_q};
  wire logic [1:0] op_next  = cmd_next[adc_port_pkg::CMD_OP_POS +: 2];
  wire logic       sel_data = cmd_next[adc_port_pkg::CMD_LEN_POS];
  wire logic [7:0] status_word = 8'(new_ready_q) << adc_port_pkg::STATUS_READY_POS;
  wire logic [DATA_W-1:0] load_word = sel_data ? buf_mem_q[rd_ptr_q]
                                    : {status_word, {(DATA_W-8){1'b0}}};
  // only a read pops; an all-ones no-op command must not eat a waiting result
  assign buf_pop = lead_edge && (state_q == ST_CMD) && (bit_cnt_q == 5'(CMD_W-1))
                   && (op_next == adc_port_pkg::OP_READ || op_next == adc_port_pkg::OP_CONT_READ)
                   && sel_data && !buf_empty;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_CMD;
      bit_cnt_q  <= 5'h00;
      len_q      <= adc_port_pkg::LEN_STATUS;
      cmd_q      <= '0;
      sh_in_q    <= '0;
      sh_out_q   <= '0;
      data_sel_q <= 1'b0;
    end else if (lead_edge) begin
      unique case (state_q)
        ST_CMD: begin
          cmd_q     <= cmd_next;
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == 5'(CMD_W-1)) begin
            bit_cnt_q  <= 5'h00;
            data_sel_q <= sel_data;
            len_q      <= sel_data ? adc_port_pkg::LEN_WORD : adc_port_pkg::LEN_STATUS;
            sh_out_q   <= load_word;
            unique case (op_next)
              adc_port_pkg::OP_WRITE:     state_q <= ST_WRITE;
              adc_port_pkg::OP_READ:      state_q <= ST_READ;
              adc_port_pkg::OP_CONT_READ: state_q <= ST_CONT;
              adc_port_pkg::OP_CONT_EXIT: state_q <= ST_CMD;
            endcase
          end
        end
        ST_WRITE: begin
          sh_in_q   <= {sh_in_q[DATA_W-2:0], din_q};
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == len_q - 5'h01) begin
            bit_cnt_q <= 5'h00;
            state_q   <= ST_CMD;
          end
        end
        ST_READ, ST_CONT: begin
          sh_out_q  <= {sh_out_q[DATA_W-2:0], 1'b0};
          bit_cnt_q <= bit_cnt_q + 5'h01;
          // continuous read watches din so the host can ask to leave it
          if (state_q == ST_CONT) cmd_q <= cmd_next;
          if (bit_cnt_q == len_q - 5'h01) begin
            bit_cnt_q <= 5'h00;
            // continuous read stays unless the host sent the exit pattern
            if (state_q == ST_READ) state_q <= ST_CMD;
            else if (cmd_next[adc_port_pkg::CMD_OP_POS +: 2] == adc_port_pkg::OP_CONT_EXIT) state_q <= ST_CMD;
            else sh_out_q <= buf_mem_q[rd_ptr_q];
          end
        end
        default: state_q <= ST_CMD;
      endcase
    end
  end

  // write handoff; a stalled consumer just keeps the word presented
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid_out <= 1'b0;
      wr_data_out  <= '0;
      wr_cmd_out   <= '0;
    end else if (lead_edge && state_q == ST_WRITE && bit_cnt_q == len_q - 5'h01) begin
      wr_valid_out <= 1'b1;
      wr_data_out  <= {sh_in_q[DATA_W-2:0], din_q};
      wr_cmd_out   <= cmd_q;
    end else if (wr_ready_in) begin
      wr_valid_out <= 1'b0;
    end
  end

  // ready: set on new result, cleared once the last buffered result is taken; set wins
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) new_ready_q <= 1'b0;
    else if (buf_push) new_ready_q <= 1'b1;
    else if (buf_pop && buf_cnt_q == 2'h1) new_ready_q <= 1'b0;
  end

  // pin, output driver; sampled by the host just before the leading edge
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ready_n_out <= adc_port_pkg::READY_N_RESET;
      dout_out    <= 1'b0;
      dout_oe_out <= 1'b0;
    end else begin
      ready_n_out <= !new_ready_q;
      dout_out    <= sh_out_q[DATA_W-1];
      dout_oe_out <= active && (state_q == ST_READ || state_q == ST_CONT);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_write_no_drive: assert property (@(posedge clk_in) disable iff (!rst_n)
    $past(state_q) == ST_WRITE |-> !dout_oe_out) else $error("output driven during write");
  a_idle_floats: assert property (@(posedge clk_in) disable iff (!rst_n)
    $past(cs_n_q) |-> !dout_oe_out) else $error("output driven while deselected");
  a_ready_pin_tracks: assert property (@(posedge clk_in) disable iff (!rst_n)
    buf_push |=> ##1 !ready_n_out) else $error("ready pin missed new result");
  a_ready_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n)
    buf_push |=> new_ready_q) else $error("ready flag not set");
  a_write_returns_cmd: assert property (@(posedge clk_in) disable iff (!rst_n)
    (lead_edge && state_q == ST_WRITE && bit_cnt_q == len_q - 5'h01) |=> state_q == ST_CMD)
    else $error("no return to command after write");
  a_msb_first_out: assert property (@(posedge clk_in) disable iff (!rst_n)
    (lead_edge && state_q == ST_READ && bit_cnt_q != len_q - 5'h01) |=> sh_out_q[DATA_W-1] == $past(sh_out_q[DATA_W-2]))
    else $error("read shift order wrong");
  a_deselect_holds: assert property (@(posedge clk_in) disable iff (!rst_n)
    cs_n_q |=> $stable(state_q) && $stable(bit_cnt_q)) else $error("state moved while deselected");
  a_write_word_msb: assert property (@(posedge clk_in) disable iff (!rst_n)
    (lead_edge && state_q == ST_WRITE && bit_cnt_q == len_q - 5'h01) |=> wr_valid_out && wr_data_out[0] == $past(din_q))
    else $error("write word assembled wrong");
  c_write_done: cover property (@(posedge clk_in) wr_valid_out && wr_ready_in);
  c_read_word: cover property (@(posedge clk_in) state_q == ST_READ && data_sel_q);
  c_buf_full: cover property (@(posedge clk_in) !result_ready_out);
  c_cont_read: cover property (@(posedge clk_in) state_q == ST_CONT);
endmodule : adc_host_serial_port
`default_nettype wire

// file: hdl/adc_port_pkg.sv
// constants for the converter's host serial port
`default_nettype none
package adc_port_pkg;
  localparam int unsigned SYNC_STAGES      = 3;
  localparam int unsigned DATA_W           = 24;
  localparam int unsigned CMD_W            = 8;
  localparam logic [1:0]  OP_WRITE         = 2'h0;
  localparam logic [1:0]  OP_READ          = 2'h1;
  localparam logic [1:0]  OP_CONT_READ     = 2'h2;
  localparam logic [1:0]  OP_CONT_EXIT     = 2'h3;
  localparam int unsigned CMD_OP_POS       = 4;
  localparam int unsigned CMD_LEN_POS      = 0;
  localparam logic [4:0]  LEN_STATUS       = 5'h08;
  localparam logic [4:0]  LEN_WORD         = 5'h18;
  localparam int unsigned STATUS_READY_POS = 7;
  localparam logic [7:0]  STATUS_RESET     = 8'h00;
  localparam logic        READY_N_RESET    = 1'h1;
  localparam int unsigned SCLK_MAX_HZ      = 3000000;
  localparam int unsigned CLK_HZ           = 200000000;
  localparam int unsigned SCLK_MIN_HALF    = CLK_HZ / (2 * SCLK_MAX_HZ);
endpackage : adc_port_pkg
`default_nettype wire

// file: verif/adc_host_model.sv
// host serial port model: clocks commands and words through the port
`default_nettype none
module adc_host_model (
  input  wire logic clk_in,
  input  wire logic pol_in,
  input  wire logic hold_cs_in,
  input  wire logic dout_in,
  input  wire logic dout_oe_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      din_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 40;
  logic receive_frame_sync_n = 1'b1, transmit_frame_sync_n = 1'b1;
  logic lead = 1'b0, drv = 1'b0, d = 1'b0, flt = 1'b0, wr_phase = 1'b0;
  ////////////////////////////////////////////////////////////
  assign sclk_out = lead ? ~pol_in : pol_in;
  assign cs_n_out = receive_frame_sync_n & transmit_frame_sync_n & ~hold_cs_in;
  // shared line; released it toggles so no stale level can pass
  assign din_out = dout_oe_in ? dout_in : (drv ? d : flt);
  always @(negedge clk_in) flt <= ~flt;
  // read bit taken before the leading edge that moves the line on
  task automatic bit_step(input logic b, input logic rd, output logic s);
    drv = ~rd;
    d = b;
    repeat (HALF) @(negedge clk_in);
    s = din_out;
    lead = 1'b1;
    repeat (HALF) @(negedge clk_in);
    lead = 1'b0;
  endtask : bit_step
  // never sends continuous read: the data line is shared
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] w, input int n, input logic sel,
                      output logic [23:0] r);
    logic s, rd;
    rd = (cmd[5:4] == adc_port_pkg::OP_READ);
    r = 24'h0;
    receive_frame_sync_n = ~(sel & rd);
    transmit_frame_sync_n = ~(sel & ~rd);
    for (int i = 7; i >= 0; i--) bit_step(cmd[i], 1'b0, s);
    wr_phase = ~rd;
    for (int i = n - 1; i >= 0; i--) begin
      bit_step(w[i], rd, s);
      r = {r[22:0], s};
    end
    wr_phase = 1'b0;
    drv = 1'b0;
    repeat (HALF) @(negedge clk_in);
    receive_frame_sync_n = 1'b1;
    transmit_frame_sync_n = 1'b1;
    repeat (HALF) @(negedge clk_in);
  endtask : xfer
endmodule : adc_host_model
`default_nettype wire

// file: verif/test_adc_host_serial_port.sv
// self-checking bench for the converter host serial port
`default_nettype none
module test_adc_host_serial_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] RDY = 24'h1 << adc_port_pkg::STATUS_READY_POS;
  logic        clk_in = 1'b0, resetn_in = 1'b0, clock_polarity_select = 1'b0, hold_cs = 1'b0, rvalid = 1'b0, wr_ready = 1'b0;
  logic        sclk, cs_n, din, dout, oe, rready, ready_n, wr_valid;
  logic [23:0] rdata = 24'h0, r, wr_data;
  logic [7:0]  wr_cmd, csh = 8'hff;
  int          bad_count = 0, num_checks = 0, cycles = 0;
  ////////////////////////////////////////////////////////////
  always #2.5 clk_in = ~clk_in;
  adc_host_serial_port i_adc_host_serial_port (.clk_in(clk_in), .resetn_in(resetn_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .din_in(din), .clock_polarity_select_in(clock_polarity_select), .result_data_in(rdata),
    .result_valid_in(rvalid), .result_ready_out(rready), .dout_out(dout), .dout_oe_out(oe),
    .ready_n_out(ready_n), .wr_data_out(wr_data), .wr_cmd_out(wr_cmd), .wr_valid_out(wr_valid),
    .wr_ready_in(wr_ready));
  adc_host_model i_adc_host_model (.clk_in(clk_in), .pol_in(clock_polarity_select), .hold_cs_in(hold_cs), .dout_in(dout),
    .dout_oe_in(oe), .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wait_clk
  task automatic rd(input logic [7:0] cmd, input int n, input logic [23:0] exp);
    i_adc_host_model.xfer(cmd, 24'h0, n, 1'b1, r);
    chk(r, exp);
  endtask : rd
  ////////////////////////////////////////////////////////////
  task automatic t_ready_read();
    rd(8'h10, 8, 24'h0);
    rdata = 24'ha5c3e1;
    rvalid = 1'b1;
    wait_clk(1);
    rvalid = 1'b0;
    wait_clk(4);
    chk(ready_n, 1'b0);
    rd(8'h10, 8, RDY);
    rd(8'h11, 24, 24'ha5c3e1);
    chk(ready_n, 1'b1);
  endtask : t_ready_read
  task automatic t_write();
    i_adc_host_model.xfer(8'h01, 24'h3c5a96, 24, 1'b1, r);
    wait_clk(8);
    chk(wr_valid, 1'b1);
    chk({wr_cmd, wr_data[15:0]}, 24'h015a96);
    chk(wr_data[23:16], 8'h3c);
    wr_ready = 1'b1;
    wait_clk(1);
    wr_ready = 1'b0;
    wait_clk(1);
    chk(wr_valid, 1'b0);
    // trailing ones form a no-op command; a waiting result must survive it
    rdata = 24'h5a5a5a;
    rvalid = 1'b1;
    wait_clk(1);
    rvalid = 1'b0;
    i_adc_host_model.xfer(8'hff, 24'h0, 0, 1'b1, r);
    rd(8'h10, 8, RDY);
    chk(wr_valid, 1'b0);
    rd(8'h11, 24, 24'h5a5a5a);
  endtask : t_write
  task automatic t_idle_cs();
    if (!hold_cs) i_adc_host_model.xfer(8'h01, 24'h123456, 24, 1'b0, r);
    chk(wr_valid, 1'b0);
    rd(8'h10, 8, 24'h0);
  endtask : t_idle_cs
  task automatic t_buffer();
    rdata = 24'h111111;
    rvalid = 1'b1;
    wait_clk(1);
    rdata = 24'h222222;
    wait_clk(1);
    rvalid = 1'b0;
    chk(rready, 1'b0);
    rd(8'h11, 24, 24'h111111);
    chk({ready_n, rready}, 24'h1);
    rd(8'h11, 24, 24'h222222);
    chk(ready_n, 1'b1);
  endtask : t_buffer
  ////////////////////////////////////////////////////////////
  // oe must lag a raised chip select by at most a few cycles
  always @(negedge clk_in) begin
    csh <= {csh[6:0], cs_n};
    if (&csh || i_adc_host_model.wr_phase) chk(oe, 1'b0);
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    wait_clk(4);
    resetn_in = 1'b1;
    wait_clk(12);
    chk({ready_n, oe, wr_valid, rready}, 24'h9);
    for (int p = 0; p < 2; p++) begin
      clock_polarity_select = p[0];
      wait_clk(20);
      hold_cs = p[0];
      wait_clk(20);
      t_ready_read();
      t_write();
      t_idle_cs();
      t_buffer();
    end
    conclude();
  end
endmodule : test_adc_host_serial_port
`default_nettype wire
